// >>> design/wpc_pkg.sv
// Package for the write-protection and configuration register block.
// Assumes a single 50 MHz clock and an instruction decoder outside the block.
package wpc_pkg;
    // Register addresses on the instruction address bus
    localparam logic [23:0] ADDR_STATUS = 24'h000000;
    localparam logic [23:0] ADDR_CONFIG_ONE = 24'h000002;
    localparam logic [23:0] ADDR_FLAG = 24'h00000a;
    localparam logic [23:0] ADDR_IDENT = 24'h000030;
    // Status register field positions
    localparam int SR_PIN_EN = 7;
    localparam int SR_BOTTOM = 5;
    localparam int SR_BLK_HI = 4;
    localparam int SR_BLK_LO = 2;
    localparam int SR_LATCH = 1;
    // Config one field positions
    localparam int CF_DRV_HI = 7;
    localparam int CF_DRV_LO = 5;
    localparam int CF_LOCK = 2;
    localparam int CF_POL_HI = 1;
    localparam int CF_POL_LO = 0;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_ONE_RESET = 8'h60;
    localparam int FLAG_READY_BIT = 7;
    // Latch clear policy codes
    localparam logic [1:0] POL_NORMAL = 2'h0;
    localparam logic [1:0] POL_SRAM = 2'h1;
    localparam logic [1:0] POL_B2B = 2'h2;
    // Identification fields, arbitrary values
    localparam logic [7:0] ID_MAKER = 8'h5a;
    localparam logic [3:0] ID_IFACE = 4'h3;
    localparam logic [3:0] ID_VOLT = 4'h4;
    localparam logic [3:0] ID_TEMP = 4'h5;
    localparam logic [3:0] ID_DENS = 4'h6;
    localparam logic [7:0] ID_FREQ = 8'h07;
    // Array geometry
    localparam int ADDR_W = 23;
endpackage

// >>> design/wpc_write_protect.sv
// Write-protection decision and status/config registers of a serial memory.
// Assumes an instruction decoder that presents one-cycle command strobes.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - With bottom select set, block select codes 1..3 protect from zero through 01ffff, 03ffff, 07ffff; code 0 protects nothing.
// - With the latch clear, register writes are refused, and array writes too except under policy 01.
// - With the latch set, register writes pass unless pin protect is on and the pin is low.
// - Protected array addresses are never written; others follow the latch, or pass under policy 01.
// - Flag status reads ready in bit 7, resets ready, other bits zero, read only.
// - Identification reads maker, interface, voltage, temperature, density, frequency fields.
// - With the lock bit set, bottom select and block select cannot change.
// - Policy 00 needs the latch per array write; chip select high clears it.
// - Policy 01 accepts array writes whatever the latch holds.
// - Policy 10 keeps the latch over chip select release until write disable, unless a register write was granted since the last release.
// - Software block select is ORed with the hardware protect pins.
// - Status holds pin enable, bottom select, block select and read-only latch, reset zero.
// - Register writes always need the latch; chip select high after one clears it.
module wpc_write_protect #(
    parameter int ADDR_W = wpc_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic csRise,
    input wire logic cmdWriteEnable,
    input wire logic cmdWriteDisable,
    input wire logic regWrite,
    input wire logic [23:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic arrayWrite,
    input wire logic [ADDR_W-1:0] arrayAddr,
    input wire logic busy,
    input wire logic protectPin_n,
    input wire logic [2:0] hwBlockProtect,
    input wire logic hwProtectFromBottom,
    output logic regWriteGrant,
    output logic arrayWriteGrant,
    output logic [31:0] regRdata,
    output logic [2:0] driveStrengthSelect
);
    // Only the 23-bit array geometry is decoded
    if (ADDR_W != 23) begin : gBadWidth
        $error("wpc_write_protect: only a 23-bit array is served");
    end

    logic [7:0] statusReg_r, statusReg_nxt;
    logic [7:0] configOne_r, configOne_nxt;
    logic regGrant_r, regGrant_nxt;
    logic arrGrant_r, arrGrant_nxt;
    logic regSinceCs_r, regSinceCs_nxt; // Granted register write since last release
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] flagStatus;
    logic latch, locked, regOk, latchOk, inRange;
    logic [2:0] blkSel;
    logic fromBottom;
    logic [1:0] policy;
    logic [ADDR_W-1:0] boundMask;

    ////////////////////////////////////////////////////////////////////////////
    // Protection decision
    always_comb begin
        latch = statusReg_r[wpc_pkg::SR_LATCH];
        locked = configOne_r[wpc_pkg::CF_LOCK];
        policy = configOne_r[wpc_pkg::CF_POL_HI:wpc_pkg::CF_POL_LO];
        blkSel = statusReg_r[wpc_pkg::SR_BLK_HI:wpc_pkg::SR_BLK_LO] | hwBlockProtect;
        fromBottom = statusReg_r[wpc_pkg::SR_BOTTOM] | hwProtectFromBottom;
        case (blkSel)
            3'h1: boundMask = 23'h01ffff;
            3'h2: boundMask = 23'h03ffff;
            3'h3: boundMask = 23'h07ffff;
            3'h4: boundMask = 23'h0fffff;
            3'h5: boundMask = 23'h1fffff;
            3'h6: boundMask = 23'h3fffff;
            3'h7: boundMask = 23'h7fffff;
            default: boundMask = 23'h000000;
        endcase
        if (blkSel == 3'h0) begin
            inRange = 1'b0;
        end else if (fromBottom) begin
            inRange = (arrayAddr & ~boundMask) == '0;
        end else begin
            inRange = (arrayAddr & ~boundMask) == ~boundMask;
        end
        regOk = latch && !(statusReg_r[wpc_pkg::SR_PIN_EN] && !protectPin_n);
        latchOk = latch || (policy == wpc_pkg::POL_SRAM);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register next state
    always_comb begin
        statusReg_nxt = statusReg_r;
        configOne_nxt = configOne_r;
        regGrant_nxt = 1'b0;
        arrGrant_nxt = 1'b0;
        regSinceCs_nxt = regSinceCs_r;
        if (arrayWrite) begin
            arrGrant_nxt = latchOk && !inRange;
        end
        if (regWrite && regOk) begin
            regGrant_nxt = 1'b1;
            if (regAddr == wpc_pkg::ADDR_STATUS) begin
                statusReg_nxt[wpc_pkg::SR_PIN_EN] = regWdata[wpc_pkg::SR_PIN_EN];
                statusReg_nxt[6] = regWdata[6];
                statusReg_nxt[0] = regWdata[0];
                if (!locked) begin
                    statusReg_nxt[wpc_pkg::SR_BOTTOM] = regWdata[wpc_pkg::SR_BOTTOM];
                    statusReg_nxt[wpc_pkg::SR_BLK_HI:wpc_pkg::SR_BLK_LO] =
                        regWdata[wpc_pkg::SR_BLK_HI:wpc_pkg::SR_BLK_LO];
                end
            end else if (regAddr == wpc_pkg::ADDR_CONFIG_ONE) begin
                configOne_nxt = regWdata & 8'he7;
            end
        end
        // Latch set and clear; set wins over release
        if (cmdWriteDisable) begin
            statusReg_nxt[wpc_pkg::SR_LATCH] = 1'b0;
        // release clears except back-to-back array use
        end else if (csRise && !cmdWriteEnable) begin
            if (policy != wpc_pkg::POL_B2B || regSinceCs_r) begin
                statusReg_nxt[wpc_pkg::SR_LATCH] = 1'b0;
            end
        end
        if (cmdWriteEnable) begin
            statusReg_nxt[wpc_pkg::SR_LATCH] = 1'b1;
        end
        if (csRise) begin
            regSinceCs_nxt = 1'b0;
        end else if (regGrant_nxt) begin
            regSinceCs_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    always_comb begin
        flagStatus = 8'h00;
        flagStatus[wpc_pkg::FLAG_READY_BIT] = !busy;
        case (regAddr)
            wpc_pkg::ADDR_STATUS: rdata_nxt = {24'h000000, statusReg_nxt};
            wpc_pkg::ADDR_CONFIG_ONE: rdata_nxt = {24'h000000, configOne_nxt};
            wpc_pkg::ADDR_FLAG: rdata_nxt = {24'h000000, flagStatus};
            wpc_pkg::ADDR_IDENT: rdata_nxt = {wpc_pkg::ID_MAKER, wpc_pkg::ID_IFACE, wpc_pkg::ID_VOLT,
                wpc_pkg::ID_TEMP, wpc_pkg::ID_DENS, wpc_pkg::ID_FREQ};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            statusReg_r <= wpc_pkg::STATUS_RESET;
            configOne_r <= wpc_pkg::CONFIG_ONE_RESET;
            regGrant_r <= 1'b0;
            arrGrant_r <= 1'b0;
            regSinceCs_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            statusReg_r <= statusReg_nxt;
            configOne_r <= configOne_nxt;
            regGrant_r <= regGrant_nxt;
            arrGrant_r <= arrGrant_nxt;
            regSinceCs_r <= regSinceCs_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from registers
    assign regWriteGrant = regGrant_r;
    assign arrayWriteGrant = arrGrant_r;
    assign regRdata = rdata_r;
    assign driveStrengthSelect = configOne_r[wpc_pkg::CF_DRV_HI:wpc_pkg::CF_DRV_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // no latch no write
    latch_blocks_a: assert property (@(posedge clk) disable iff (!arst_n)
        regWrite && !latch |=> !regWriteGrant)
        else $error("register write granted with latch clear");
    pin_blocks_a: assert property (@(posedge clk) disable iff (!arst_n)
        regWrite && statusReg_r[wpc_pkg::SR_PIN_EN] && !protectPin_n |=> !regWriteGrant)
        else $error("register write granted while pin protected");
    range_blocks_a: assert property (@(posedge clk) disable iff (!arst_n)
        arrayWrite && inRange |=> !arrayWriteGrant)
        else $error("protected array write granted");
    bottom_low_a: assert property (@(posedge clk) disable iff (!arst_n)
        arrayWrite && fromBottom && blkSel == 3'h1 && arrayAddr == 23'h020000 && latchOk |=> arrayWriteGrant)
        else $error("address past bottom 1/64 refused");
    sram_grant_a: assert property (@(posedge clk) disable iff (!arst_n)
        arrayWrite && policy == wpc_pkg::POL_SRAM && blkSel == 3'h0 |=> arrayWriteGrant)
        else $error("sram policy write refused");
    b2b_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
        csRise && latch && policy == wpc_pkg::POL_B2B && !regSinceCs_r && !cmdWriteDisable |=> latch)
        else $error("latch lost in back-to-back mode");
    normal_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        csRise && policy == wpc_pkg::POL_NORMAL && !cmdWriteEnable |=> !latch)
        else $error("latch kept after release");
    reg_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        csRise && regSinceCs_r && !cmdWriteEnable |=> !latch)
        else $error("latch kept after register write release");
    lock_holds_a: assert property (@(posedge clk) disable iff (!arst_n)
        locked |=> $stable(statusReg_r[5:2]) || !$past(locked))
        else $error("locked protection fields changed");
    flag_read_a: assert property (@(posedge clk) disable iff (!arst_n)
        regAddr == wpc_pkg::ADDR_FLAG |=> regRdata[6:0] == 7'h00)
        else $error("flag reserved bits nonzero");
endmodule

// >>> tb/wpc_host_model.sv
// Host model: one-cycle instruction strobes for the protection block.
// Assumes callers wait on the falling edge; the block samples on the rise.
`timescale 1ns/1ps
module wpc_host_model (
    input wire logic clk,
    output logic csRise,
    output logic cmdWriteEnable,
    output logic cmdWriteDisable,
    output logic regWrite,
    output logic arrayWrite,
    output logic [23:0] regAddr,
    output logic [7:0] regWdata,
    output logic [22:0] arrayAddr
);
    // Idle lines at time zero
    initial begin
        {csRise, cmdWriteEnable, cmdWriteDisable, regWrite, arrayWrite, regAddr, regWdata, arrayAddr} = '0;
    end
    ////////////////////////////////////////////////////////////
    // Kinds: 0 set latch, 1 clear latch, 2 release, 3 reg, 4 array, 5 read
    task automatic inst(input int k, input logic [23:0] a, input logic [7:0] d);
        @(negedge clk);
        if (k == 3 && a == wpc_pkg::ADDR_CONFIG_ONE && d[1:0] == 2'h3) d[0] = 1'b0;
        {csRise, cmdWriteEnable, cmdWriteDisable, regWrite, arrayWrite} = {k == 2, k == 0, k == 1, k == 3, k == 4};
        regAddr = a;
        regWdata = d;
        arrayAddr = a[22:0];
        @(negedge clk);
        {csRise, cmdWriteEnable, cmdWriteDisable, regWrite, arrayWrite} = 5'h00;
        regWdata = ~d; // Released data does not hold its value
        arrayAddr = ~a[22:0];
    endtask
endmodule

// >>> tb/write_protect_and_config_regs_tb.sv
// Bench for the write-protection block driven through the host model.
// Assumes one-cycle grant latency and one-cycle read-data lag.
`timescale 1ns/1ps
module write_protect_and_config_regs_tb;
    localparam logic [23:0] STA = wpc_pkg::ADDR_STATUS;
    localparam logic [23:0] CFG = wpc_pkg::ADDR_CONFIG_ONE;
    localparam logic [23:0] UNP = 24'h7fff00;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic busy = 1'b0;
    logic protectPin_n = 1'b1;
    logic hwProtectFromBottom = 1'b0;
    logic [2:0] hwBlockProtect = 3'h0;
    logic csRise, cmdWriteEnable, cmdWriteDisable, regWrite, arrayWrite, regWriteGrant, arrayWriteGrant;
    logic [23:0] regAddr, lim;
    logic [7:0] regWdata;
    logic [22:0] arrayAddr;
    logic [31:0] regRdata;
    logic [2:0] driveStrengthSelect;
    int nFail = 0;
    int nChecks = 0;
    wpc_host_model host (.clk(clk), .csRise(csRise), .cmdWriteEnable(cmdWriteEnable),
        .cmdWriteDisable(cmdWriteDisable), .regWrite(regWrite), .arrayWrite(arrayWrite),
        .regAddr(regAddr), .regWdata(regWdata), .arrayAddr(arrayAddr));
    wpc_write_protect dut (.clk(clk), .arst_n(arst_n), .csRise(csRise), .cmdWriteEnable(cmdWriteEnable),
        .cmdWriteDisable(cmdWriteDisable), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
        .arrayWrite(arrayWrite), .arrayAddr(arrayAddr), .busy(busy), .protectPin_n(protectPin_n),
        .hwBlockProtect(hwBlockProtect), .hwProtectFromBottom(hwProtectFromBottom),
        .regWriteGrant(regWriteGrant), .arrayWriteGrant(arrayWriteGrant), .regRdata(regRdata),
        .driveStrengthSelect(driveStrengthSelect));
    // 50 MHz clock
    initial forever #10 clk = ~clk;
    ////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One instruction, grant compared for writes
    task automatic op(input int k, input logic [23:0] a, input logic [7:0] d, input logic g);
        host.inst(k, a, d);
        if (k > 2) check({31'h0, k == 3 ? regWriteGrant : arrayWriteGrant}, {31'h0, g});
    endtask
    task automatic rd(input logic [23:0] a, input logic [31:0] exp);
        host.inst(5, a, 8'h00);
        check(regRdata, exp);
    endtask
    // Latch, write, release
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        op(0, 0, 0, 0);
        op(3, a, d, 1'b1);
        op(2, 0, 0, 0);
    endtask
    task automatic testDone();
        $display("checks %0d errors %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        rd(STA, 32'h0);
        rd(CFG, 32'h60);
        check({29'h0, driveStrengthSelect}, 32'h3);
        rd(wpc_pkg::ADDR_FLAG, 32'h80);
        busy = 1'b1;
        rd(wpc_pkg::ADDR_FLAG, 32'h0);
        busy = 1'b0;
        rd(wpc_pkg::ADDR_IDENT, {wpc_pkg::ID_MAKER, wpc_pkg::ID_IFACE, wpc_pkg::ID_VOLT, wpc_pkg::ID_TEMP,
            wpc_pkg::ID_DENS, wpc_pkg::ID_FREQ});
        op(3, STA, 8'h24, 1'b0);
        op(4, UNP, 0, 1'b0);
        op(0, 0, 0, 0);
        op(3, STA, 8'h24, 1'b1);
        rd(STA, 32'h26);
        op(2, 0, 0, 0);
        rd(STA, 32'h24);
        op(4, UNP, 0, 1'b0);
        for (int c = 1; c < 8; c++) begin
            lim = (24'h010000 << c) - 24'h1;
            wr(STA, {3'h1, c[2:0], 2'h0});
            op(0, 0, 0, 0);
            op(4, lim, 0, 1'b0);
            op(4, lim + 24'h1, 0, c < 7);
            op(2, 0, 0, 0);
        end
        wr(STA, 8'h20);
        {hwProtectFromBottom, hwBlockProtect} = 4'h9;
        op(0, 0, 0, 0);
        op(4, 24'h0, 0, 1'b0);
        op(4, 24'h020000, 0, 1'b1);
        hwBlockProtect = 3'h0;
        op(4, 24'h0, 0, 1'b1);
        op(2, 0, 0, 0);
        hwProtectFromBottom = 1'b0;
        wr(STA, 8'h80);
        protectPin_n = 1'b0;
        op(0, 0, 0, 0);
        op(3, STA, 8'h00, 1'b0);
        op(4, UNP, 0, 1'b1);
        op(2, 0, 0, 0);
        protectPin_n = 1'b1;
        hwBlockProtect = 3'h1;
        op(0, 0, 0, 0);
        op(4, 24'h7e0000, 0, 1'b0);
        op(4, 24'h7dffff, 0, 1'b1);
        op(2, 0, 0, 0);
        hwBlockProtect = 3'h0;
        wr(CFG, 8'h64);
        wr(STA, 8'h3c);
        rd(STA, 32'h0);
        wr(CFG, 8'hb9);
        rd(CFG, 32'ha1);
        check({29'h0, driveStrengthSelect}, 32'h5);
        op(4, UNP, 0, 1'b1);
        wr(CFG, 8'h62);
        rd(STA, 32'h0);
        op(0, 0, 0, 0);
        op(2, 0, 0, 0);
        rd(STA, 32'h2);
        op(4, UNP, 0, 1'b1);
        op(2, 0, 0, 0);
        op(4, UNP, 0, 1'b1);
        op(1, 0, 0, 0);
        op(4, UNP, 0, 1'b0);
        testDone();
    end
endmodule
